// *** logic/flash_cmd_status.sv ***
// Command interpreter and status registers of the flash card
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module flash_cmd_status
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus cycles
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic word_mode,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] wdata,
  output logic [flash_cmd_pkg::DATA_W-1:0] rdata,
  output logic rd_valid,
  // Flash array and write engine
  input wire logic [flash_cmd_pkg::DATA_W-1:0] array_rdata,
  input wire logic engine_busy,
  input wire logic engine_op_erase,
  input wire logic [flash_cmd_pkg::BLK_W-1:0] engine_block,
  input wire logic engine_write_err,
  input wire logic engine_erase_err,
  input wire logic engine_vpp_low,
  input wire logic erase_suspended_flag,
  input wire logic queue_full_flag,
  input wire logic [flash_cmd_pkg::NBLK-1:0] lock_nv,
  // Commands towards the engine
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [flash_cmd_pkg::ADDR_W-1:0] cmd_addr,
  output logic [flash_cmd_pkg::DATA_W-1:0] cmd_data,
  output logic [7:0] cmd_count,
  output logic cmd_pb,
  // Ready/busy pin
  output logic ready_busy_output
);
  import flash_cmd_pkg::*;
  typedef struct packed {
    seq_type seq;
    read_type rmode;
    rb_type rbmode;
    logic [7:0] first;
    logic [CNT_W-1:0] remain;
    logic active_pb;
    logic sleeping;
    logic busy_d;
    logic erase_err;
    logic write_err;
    logic vpp_low;
    logic gsr_err;
    logic [NBLK-1:0] unlocked;
    logic [NBLK-1:0] blk_err;
    logic [NBLK-1:0] blk_abort;
    logic [NBLK-1:0] blk_vpp;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;
    logic [7:0] cmd_count;
    logic rd_s1;
    read_type rd_mode;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rdata;
    logic rd_valid;
    logic rb;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic [7:0] code;
  logic code_ok;
  logic [BLK_W-1:0] blk;
  logic [7:0] csr_byte;
  logic [7:0] gsr_byte;
  logic [7:0] bsr_word [NBLK];
  logic pb_we;
  logic [DATA_W-1:0] pb_rdata;

  //////////////////////////////////////////////////////////////////////////
  // Code decode; word mode needs the same code in both bytes
  assign code = wdata[7:0];
  assign code_ok = !word_mode || (wdata[15:8] == wdata[7:0]);
  assign blk = addr[ADDR_W-1:BLK_LSB];
  assign pb_we = wr_en && (s_r.seq == SEQ_LOAD);

  // Legacy status, same layout as the earlier single register
  always_comb begin
    csr_byte = '0;
    csr_byte[CSR_READY] = !engine_busy;
    csr_byte[CSR_SUSP] = erase_suspended_flag;
    csr_byte[CSR_ERASE_ERR] = s_r.erase_err;
    csr_byte[CSR_WRITE_ERR] = s_r.write_err;
    csr_byte[CSR_VPP] = s_r.vpp_low;
  end

  // Device-wide status: queue and page buffer state
  always_comb begin
    gsr_byte = '0;
    gsr_byte[GSR_READY] = !engine_busy;
    gsr_byte[GSR_SLEEP] = s_r.sleeping;
    gsr_byte[GSR_OP_ERR] = s_r.gsr_err;
    gsr_byte[GSR_QUEUE] = queue_full_flag;
    gsr_byte[GSR_LOADING] = (s_r.seq == SEQ_LOAD);
    gsr_byte[GSR_ACTIVE_PB] = s_r.active_pb;
  end

  // One status byte per block
  for (genvar b = 0; b < NBLK; b++) begin : g_bsr
    always_comb begin
      bsr_word[b] = '0;
      bsr_word[b][BSR_READY] =
        !(engine_busy && (engine_block == BLK_W'(b)));
      bsr_word[b][BSR_UNLOCK] = s_r.unlocked[b];
      bsr_word[b][BSR_OP_ERR] = s_r.blk_err[b];
      bsr_word[b][BSR_ABORT] = s_r.blk_abort[b];
      bsr_word[b][BSR_QUEUE] = queue_full_flag;
      bsr_word[b][BSR_VPP] = s_r.blk_vpp[b];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state: sequencer, status flags, read path and ready/busy
  always_comb begin
    logic iss;
    logic [7:0] iss_code;
    logic [ADDR_W-1:0] iss_addr;
    logic seq_err;
    logic done;
    iss = 1'b0;
    iss_code = code;
    iss_addr = addr;
    seq_err = 1'b0;
    done = s_r.busy_d && !engine_busy;
    s_nxt = s_r;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.rd_valid = 1'b0;
    s_nxt.busy_d = engine_busy;
    if (wr_en) begin
      case (s_r.seq)
        SEQ_IDLE: begin
          if (code_ok) begin
            s_nxt.sleeping = 1'b0;
            s_nxt.first = code;
            case (code)
              OP_READ_ARRAY: s_nxt.rmode = RD_ARRAY;
              OP_READ_CSR: s_nxt.rmode = RD_CSR;
              OP_READ_EXT: s_nxt.rmode = RD_EXT;
              OP_PB_READ: s_nxt.rmode = RD_PB;
              OP_CLEAR: begin
                s_nxt.erase_err = 1'b0;
                s_nxt.write_err = 1'b0;
                s_nxt.vpp_low = 1'b0;
                s_nxt.gsr_err = 1'b0;
                s_nxt.blk_err = '0;
                s_nxt.blk_vpp = '0;
              end
              OP_SWAP: s_nxt.active_pb = !s_r.active_pb;
              OP_SLEEP: begin
                s_nxt.sleeping = 1'b1;
                iss = 1'b1;
              end
              OP_ABORT: begin
                iss = 1'b1;
                if (engine_busy) begin
                  s_nxt.blk_abort[engine_block] = 1'b1;
                end
              end
              OP_SUSPEND: begin
                iss = 1'b1;
                s_nxt.rmode = RD_CSR;
              end
              OP_CONFIRM: iss = 1'b1;
              OP_WRITE, OP_WRITE_ALT: begin
                s_nxt.seq = SEQ_WDATA;
                s_nxt.rmode = RD_CSR;
              end
              OP_ERASE, OP_LOCK, OP_UPLOAD, OP_DEV_INFO, OP_ERASE_ALL,
              OP_RB_CFG: s_nxt.seq = SEQ_CONFIRM;
              OP_SEQ_LOAD, OP_PB_WRITE: s_nxt.seq = SEQ_CNT_LO;
              OP_SLOAD: begin
                s_nxt.seq = SEQ_LOAD;
                s_nxt.remain = CNT_W'(1);
              end
              default: s_nxt.sleeping = s_r.sleeping;
            endcase
          end
        end
        SEQ_WDATA: begin
          iss = 1'b1;
          iss_code = s_r.first;
          s_nxt.seq = SEQ_IDLE;
        end
        SEQ_CONFIRM: begin
          s_nxt.seq = SEQ_IDLE;
          if (s_r.first == OP_RB_CFG) begin
            if (!code_ok) seq_err = 1'b1;
            else if (code == RB_CODE_ERASE) s_nxt.rbmode = RB_PULSE_ERASE;
            else if (code == RB_CODE_WRITE) s_nxt.rbmode = RB_PULSE_WRITE;
            else if (code == RB_CODE_LEVEL) s_nxt.rbmode = RB_LEVEL;
            else if (code == RB_CODE_OFF) s_nxt.rbmode = RB_OFF;
            else seq_err = 1'b1;
          end else if (code_ok && code == OP_CONFIRM) begin
            iss = 1'b1;
            iss_code = s_r.first;
            if (s_r.first == OP_UPLOAD) begin
              s_nxt.unlocked = lock_nv;
            end else if (s_r.first == OP_LOCK) begin
              s_nxt.unlocked[blk] = 1'b0;
            end else if (s_r.first != OP_DEV_INFO) begin
              s_nxt.rmode = RD_CSR;
            end
          end else begin
            seq_err = 1'b1;
          end
        end
        SEQ_CNT_LO: begin
          s_nxt.remain = {1'b0, wdata[7:0]} + CNT_W'(1);
          s_nxt.cmd_count = wdata[7:0];
          s_nxt.seq = SEQ_CNT_HI;
        end
        SEQ_CNT_HI: begin
          // High count byte is ignored: host keeps it zero
          if (s_r.first == OP_PB_WRITE) begin
            iss = 1'b1;
            iss_code = s_r.first;
            iss_addr = {addr[ADDR_W-1:1], !addr[0]};
            s_nxt.rmode = RD_CSR;
            s_nxt.seq = SEQ_IDLE;
          end else begin
            s_nxt.seq = SEQ_LOAD;
          end
        end
        SEQ_LOAD: begin
          s_nxt.remain = s_r.remain - CNT_W'(1);
          if (s_r.remain == CNT_W'(1)) s_nxt.seq = SEQ_IDLE;
        end
        default: s_nxt.seq = SEQ_IDLE;
      endcase
    end
    // Engine events set after clears, so a same-cycle event survives
    if (engine_erase_err) begin
      s_nxt.erase_err = 1'b1;
      s_nxt.gsr_err = 1'b1;
      s_nxt.blk_err[engine_block] = 1'b1;
    end
    if (engine_write_err) begin
      s_nxt.write_err = 1'b1;
      s_nxt.gsr_err = 1'b1;
      s_nxt.blk_err[engine_block] = 1'b1;
    end
    if (engine_vpp_low) begin
      s_nxt.vpp_low = 1'b1;
      s_nxt.blk_vpp[engine_block] = 1'b1;
    end
    if (seq_err) begin
      s_nxt.erase_err = 1'b1;
      s_nxt.write_err = 1'b1;
      s_nxt.gsr_err = 1'b1;
    end
    if (iss) begin
      s_nxt.cmd_valid = 1'b1;
      s_nxt.cmd_code = iss_code;
      s_nxt.cmd_addr = iss_addr;
      s_nxt.cmd_data = wdata;
    end
    // Two-stage read: capture mode, then select the source
    s_nxt.rd_s1 = rd_en;
    s_nxt.rd_mode = s_r.rmode;
    s_nxt.rd_addr = addr;
    if (s_r.rd_s1) begin
      s_nxt.rd_valid = 1'b1;
      case (s_r.rd_mode)
        RD_CSR: s_nxt.rdata = {8'h00, csr_byte};
        RD_EXT: begin
          if (s_r.rd_addr[15:0] == EXT_GSR_LOC) begin
            s_nxt.rdata = {8'h00, gsr_byte};
          end else begin
            s_nxt.rdata =
              {8'h00, bsr_word[s_r.rd_addr[ADDR_W-1:BLK_LSB]]};
          end
        end
        RD_PB: s_nxt.rdata = pb_rdata;
        default: s_nxt.rdata = array_rdata;
      endcase
    end
    // Pulse modes give one low cycle when a matching operation ends
    case (s_r.rbmode)
      RB_LEVEL: s_nxt.rb = !engine_busy;
      RB_PULSE_ERASE: s_nxt.rb = !(done && engine_op_erase);
      RB_PULSE_WRITE: s_nxt.rb = !(done && !engine_op_erase);
      default: s_nxt.rb = 1'b1;
    endcase
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.seq = SEQ_IDLE;
      s_nxt.rmode = RD_ARRAY;
      s_nxt.rd_mode = RD_ARRAY;
      s_nxt.rbmode = RB_LEVEL;
      s_nxt.rb = 1'b1;
      s_nxt.unlocked = '0;
    end
  end

  // The whole state in one register
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  page_buffer_mem u_pb (
    .clk(clk),
    .we(pb_we),
    .waddr({s_r.active_pb, addr[PB_AW-1:0]}),
    .wdata(wdata),
    .raddr({s_r.active_pb, addr[PB_AW-1:0]}),
    .rdata_r(pb_rdata)
  );

  // Outputs straight from the state register
  assign rdata = s_r.rdata;
  assign rd_valid = s_r.rd_valid;
  assign cmd_valid = s_r.cmd_valid;
  assign cmd_code = s_r.cmd_code;
  assign cmd_addr = s_r.cmd_addr;
  assign cmd_data = s_r.cmd_data;
  assign cmd_count = s_r.cmd_count;
  assign cmd_pb = s_r.active_pb;
  assign ready_busy_output = s_r.rb;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_auto_csr;
    wr_en && s_r.seq == SEQ_IDLE && code_ok &&
      (code == OP_SUSPEND || code == OP_WRITE || code == OP_WRITE_ALT)
      |=> s_r.rmode == RD_CSR;
  endproperty
  a_auto_csr: assert property (p_auto_csr)
    else $error("suspend did not switch reads to legacy status");

  property p_clear;
    wr_en && s_r.seq == SEQ_IDLE && code_ok && code == OP_CLEAR &&
      !engine_erase_err && !engine_write_err && !engine_vpp_low
      |=> !s_r.erase_err && !s_r.write_err && !s_r.vpp_low && !s_r.gsr_err &&
          s_r.blk_err == '0 && s_r.blk_vpp == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left status bits set");

  property p_ext_gsr;
    s_r.rd_s1 && s_r.rd_mode == RD_EXT && s_r.rd_addr[15:0] == EXT_GSR_LOC
      |=> rd_valid && rdata[7:0] == $past(gsr_byte);
  endproperty
  a_ext_gsr: assert property (p_ext_gsr)
    else $error("extended read did not return device status");

  property p_upload;
    wr_en && s_r.seq == SEQ_CONFIRM && s_r.first == OP_UPLOAD &&
      code_ok && code == OP_CONFIRM |=> s_r.unlocked == $past(lock_nv);
  endproperty
  a_upload: assert property (p_upload)
    else $error("lock upload did not load lock bits");

  property p_a0;
    wr_en && s_r.seq == SEQ_CNT_HI && s_r.first == OP_PB_WRITE
      |=> cmd_valid && cmd_addr[0] != $past(addr[0]);
  endproperty
  a_a0: assert property (p_a0)
    else $error("address bit zero not complemented");

  property p_swap;
    wr_en && s_r.seq == SEQ_IDLE && code_ok && code == OP_SWAP
      |=> cmd_pb != $past(cmd_pb);
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap did not toggle the page buffer");

  property p_rb_off;
    s_r.rbmode == RB_OFF |=> ready_busy_output;
  endproperty
  a_rb_off: assert property (p_rb_off)
    else $error("disabled ready/busy went low");

  property p_blk_busy;
    engine_busy |-> !bsr_word[engine_block][BSR_READY];
  endproperty
  a_blk_busy: assert property (p_blk_busy)
    else $error("busy block reads ready");

  property p_seq_err;
    wr_en && s_r.seq == SEQ_CONFIRM && s_r.first != OP_RB_CFG &&
      !(code_ok && code == OP_CONFIRM)
      |=> !cmd_valid && s_r.erase_err && s_r.write_err;
  endproperty
  a_seq_err: assert property (p_seq_err)
    else $error("bad confirm executed or not flagged");

  property p_word;
    word_mode && wr_en && s_r.seq == SEQ_IDLE && !code_ok
      |=> s_r.seq == SEQ_IDLE && !cmd_valid;
  endproperty
  a_word: assert property (p_word)
    else $error("unreplicated word code was accepted");

  c_lock: cover property (wr_en && s_r.seq == SEQ_CONFIRM &&
    s_r.first == OP_LOCK && code == OP_CONFIRM);
  c_load: cover property (s_r.seq == SEQ_LOAD ##1 s_r.seq == SEQ_IDLE);
  c_pulse: cover property (s_r.rbmode == RB_PULSE_WRITE &&
    !ready_busy_output);
endmodule // flash_cmd_status

// *** logic/flash_cmd_pkg.sv ***
// Shared constants and state types of the card command and status unit
package flash_cmd_pkg;
  // Bus and array geometry
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BLK_W = 5;
  localparam int NBLK = 32;
  localparam int BLK_LSB = 16;
  localparam int PB_AW = 8;
  localparam int CNT_W = 9;
  // Command codes, low byte of the data bus
  localparam logic [7:0] OP_READ_ARRAY = 8'hff;
  localparam logic [7:0] OP_READ_CSR = 8'h70;
  localparam logic [7:0] OP_READ_EXT = 8'h71;
  localparam logic [7:0] OP_CLEAR = 8'h50;
  localparam logic [7:0] OP_WRITE = 8'h40;
  localparam logic [7:0] OP_WRITE_ALT = 8'h10;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_SUSPEND = 8'hb0;
  localparam logic [7:0] OP_CONFIRM = 8'hd0;
  localparam logic [7:0] OP_PB_WRITE = 8'h0c;
  localparam logic [7:0] OP_SWAP = 8'h72;
  localparam logic [7:0] OP_SLOAD = 8'h74;
  localparam logic [7:0] OP_PB_READ = 8'h75;
  localparam logic [7:0] OP_LOCK = 8'h77;
  localparam logic [7:0] OP_ABORT = 8'h80;
  localparam logic [7:0] OP_RB_CFG = 8'h96;
  localparam logic [7:0] OP_UPLOAD = 8'h97;
  localparam logic [7:0] OP_DEV_INFO = 8'h99;
  localparam logic [7:0] OP_ERASE_ALL = 8'ha7;
  localparam logic [7:0] OP_SEQ_LOAD = 8'he0;
  localparam logic [7:0] OP_SLEEP = 8'hf0;
  // Second codes of the ready/busy configuration
  localparam logic [7:0] RB_CODE_ERASE = 8'hd0;
  localparam logic [7:0] RB_CODE_WRITE = 8'hd1;
  localparam logic [7:0] RB_CODE_LEVEL = 8'hd2;
  localparam logic [7:0] RB_CODE_OFF = 8'hd3;
  // Status bit positions
  localparam int CSR_READY = 7;
  localparam int CSR_SUSP = 6;
  localparam int CSR_ERASE_ERR = 5;
  localparam int CSR_WRITE_ERR = 4;
  localparam int CSR_VPP = 3;
  localparam int GSR_READY = 7;
  localparam int GSR_SLEEP = 6;
  localparam int GSR_OP_ERR = 5;
  localparam int GSR_QUEUE = 3;
  localparam int GSR_LOADING = 1;
  localparam int GSR_ACTIVE_PB = 0;
  localparam int BSR_READY = 7;
  localparam int BSR_UNLOCK = 6;
  localparam int BSR_OP_ERR = 5;
  localparam int BSR_ABORT = 4;
  localparam int BSR_QUEUE = 3;
  localparam int BSR_VPP = 2;
  // Extended status location that selects the device-wide register
  localparam logic [15:0] EXT_GSR_LOC = 16'h0002;
  // Sequencer, read mode and ready/busy mode
  typedef enum logic [5:0] {
    SEQ_IDLE = 6'h01, SEQ_WDATA = 6'h02, SEQ_CONFIRM = 6'h04,
    SEQ_CNT_LO = 6'h08, SEQ_CNT_HI = 6'h10, SEQ_LOAD = 6'h20
  } seq_type;
  typedef enum logic [3:0] {
    RD_ARRAY = 4'h1, RD_CSR = 4'h2, RD_EXT = 4'h4, RD_PB = 4'h8
  } read_type;
  typedef enum logic [3:0] {
    RB_LEVEL = 4'h1, RB_PULSE_ERASE = 4'h2, RB_PULSE_WRITE = 4'h4,
    RB_OFF = 4'h8
  } rb_type;
endpackage

// *** logic/page_buffer_mem.sv ***
// Two page buffers with registered read data
`timescale 1ns/100ps
module page_buffer_mem
  import flash_cmd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [flash_cmd_pkg::PB_AW:0] waddr,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] wdata,
  // Read port
  input wire logic [flash_cmd_pkg::PB_AW:0] raddr,
  output logic [flash_cmd_pkg::DATA_W-1:0] rdata_r
);
  import flash_cmd_pkg::*;
  logic [DATA_W-1:0] mem [0:(2**(PB_AW+1))-1];

  // Write, then registered read; contents are not reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule // page_buffer_mem

// *** tb/host_bus_model.sv ***
// Host bus model issuing command and read cycles to the card
`timescale 1ns/100ps
module host_bus_model
  import flash_cmd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus cycles towards the card
  output logic wr_en,
  output logic rd_en,
  output logic [flash_cmd_pkg::ADDR_W-1:0] addr,
  output logic [flash_cmd_pkg::DATA_W-1:0] wdata,
  // Answer from the card
  input wire logic [flash_cmd_pkg::DATA_W-1:0] rdata,
  input wire logic rd_valid
);
  import flash_cmd_pkg::*;

  // Quiet bus at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // One write per cycle, changed at the falling edge; back to back allowed
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    rd_en = 1'b0;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
  endtask

  // Released lines show the inverse, never a stale value
  task automatic idle();
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
  endtask

  // Read; answer stands between the first and second edge after taking
  task automatic get(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                     output logic v);
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
    @(negedge clk);
    v = rd_valid;
    d = rdata;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Extended status: code first, then a read at the register location
  task automatic ext_get(input logic [ADDR_W-1:0] a,
                         output logic [DATA_W-1:0] d, output logic v);
    put('0, 16'h0071);
    get(a, d, v);
  endtask

  // Lock bits stay reported locked until this upload
  task automatic upload();
    put('0, 16'h0097);
    put('0, 16'h00d0);
    idle();
  endtask

  // Lock code anywhere, confirm at the target block
  task automatic lock(input logic [BLK_W-1:0] blk);
    put('0, 16'h0077);
    put({blk, 16'h0000}, 16'h00d0);
    idle();
  endtask

  // Two words into the active buffer; high count kept at zero
  task automatic seq_load(input logic [DATA_W-1:0] w0, w1);
    put('0, 16'h00e0);
    put('0, 16'h0001);
    put('0, 16'h0000);
    put(21'h000000, w0);
    put(21'h000001, w1);
    idle();
  endtask
endmodule // host_bus_model

// *** tb/tb.sv ***
// Self-checking bench of the card command and status unit
`timescale 1ns/100ps
module tb;
  import flash_cmd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en, rd_en, rd_valid, cmd_valid, cmd_pb, ready_busy_output;
  logic [ADDR_W-1:0] addr, cmd_addr;
  logic [DATA_W-1:0] wdata, rdata, cmd_data, d;
  logic [7:0] cmd_code, cmd_count;
  logic word_mode, engine_busy, engine_op_erase, engine_write_err;
  logic engine_erase_err, engine_vpp_low, erase_suspended_flag;
  logic queue_full_flag, v, exp_pb;
  logic [DATA_W-1:0] array_rdata;
  logic [BLK_W-1:0] engine_block;
  logic [NBLK-1:0] lock_nv;
  int mismatches = 0;
  int checks_done = 0;
  int cmd_cnt = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  flash_cmd_status dut_u (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .word_mode(word_mode), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid), .array_rdata(array_rdata),
    .engine_busy(engine_busy), .engine_op_erase(engine_op_erase),
    .engine_block(engine_block), .engine_write_err(engine_write_err),
    .engine_erase_err(engine_erase_err), .engine_vpp_low(engine_vpp_low),
    .erase_suspended_flag(erase_suspended_flag),
    .queue_full_flag(queue_full_flag), .lock_nv(lock_nv),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_count(cmd_count), .cmd_pb(cmd_pb),
    .ready_busy_output(ready_busy_output));

  host_bus_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));

  // Count commands handed to the engine
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) cmd_cnt++;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Read in the current mode or extended, then compare
  task automatic expect_rd(input logic ext, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] e);
    if (ext) host_u.ext_get(a, d, v);
    else host_u.get(a, d, v);
    check({31'h0, v}, 32'h1);
    check({16'h0, d}, {16'h0, e});
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Reset values, legacy layout, array read
  task automatic t_reset();
    check({31'h0, cmd_pb}, 32'h0);
    check({31'h0, ready_busy_output}, 32'h1);
    host_u.put('0, 16'h0070);
    expect_rd(1'b0, '0, 16'h0080);
    host_u.put('0, 16'h00ff);
    expect_rd(1'b0, '0, 16'h5a5a);
  endtask

  // Power-up locks, upload, then a lock of one block
  task automatic t_locks();
    lock_nv = 32'h00000018;
    expect_rd(1'b1, 21'h030000, 16'h0080);
    host_u.upload();
    expect_rd(1'b1, 21'h030000, 16'h00c0);
    expect_rd(1'b1, 21'h050000, 16'h0080);
    host_u.lock(5'd3);
    repeat (2) @(negedge clk);
    check({24'h0, cmd_code}, 32'h77);
    expect_rd(1'b1, 21'h030000, 16'h0080);
    expect_rd(1'b1, 21'h040000, 16'h00c0);
  endtask

  // Swap with word codes; an unreplicated code must be ignored
  task automatic t_swap();
    word_mode = 1'b1;
    host_u.put('0, 16'h7272);
    host_u.put('0, 16'h7372);
    host_u.idle();
    word_mode = 1'b0;
    exp_pb = ~exp_pb;
    repeat (2) @(negedge clk);
    check({31'h0, cmd_pb}, {31'h0, exp_pb});
    host_u.put('0, 16'h0072);
    host_u.idle();
    exp_pb = ~exp_pb;
    repeat (2) @(negedge clk);
    check({31'h0, cmd_pb}, {31'h0, exp_pb});
  endtask

  // Buffer to array write; reads then switch to legacy status
  task automatic t_pb_write();
    int n;
    n = cmd_cnt;
    host_u.put('0, 16'h000c);
    host_u.put('0, 16'h0005);
    host_u.put(21'h001234, 16'h0000);
    host_u.idle();
    repeat (3) @(negedge clk);
    check(cmd_cnt, n + 1);
    check({24'h0, cmd_code}, 32'h0c);
    check({11'h0, cmd_addr}, 32'h001235);
    check({24'h0, cmd_count}, 32'h05);
    expect_rd(1'b0, '0, 16'h0080);
  endtask

  // Sequential load then page buffer reads
  task automatic t_seq_load();
    host_u.seq_load(16'ha5c3, 16'h3c5a);
    host_u.put('0, 16'h0075);
    expect_rd(1'b0, 21'h000001, 16'h3c5a);
    expect_rd(1'b0, 21'h000000, 16'ha5c3);
  endtask

  // Wrong confirm, status events, then clear
  task automatic t_seq_err();
    int n;
    n = cmd_cnt;
    host_u.put('0, 16'h0077);
    host_u.put('0, 16'h00ff);
    host_u.idle();
    repeat (3) @(negedge clk);
    check(cmd_cnt, n);
    host_u.put('0, 16'h0070);
    expect_rd(1'b0, '0, 16'h00b0);
    expect_rd(1'b1, 21'h000002, {15'h0050, exp_pb});
    queue_full_flag = 1'b1;
    engine_vpp_low = 1'b1;
    @(negedge clk);
    engine_vpp_low = 1'b0;
    host_u.put('0, 16'h0070);
    expect_rd(1'b0, '0, 16'h00b8);
    expect_rd(1'b1, '0, 16'h008c);
    host_u.put('0, 16'h0050);
    host_u.put('0, 16'h0070);
    expect_rd(1'b0, '0, 16'h0080);
    expect_rd(1'b1, '0, 16'h0088);
    expect_rd(1'b1, 21'h000002, {15'h0044, exp_pb});
    queue_full_flag = 1'b0;
  endtask

  // Suspend, sleep, an engine error and abort in turn
  task automatic t_sleep_abort();
    erase_suspended_flag = 1'b1;
    host_u.put('0, 16'h00ff);
    host_u.put('0, 16'h00b0);
    expect_rd(1'b0, '0, 16'h00c0);
    erase_suspended_flag = 1'b0;
    host_u.put('0, 16'h0071);
    host_u.put('0, 16'h00f0);
    expect_rd(1'b0, 21'h000002, {15'h0060, exp_pb});
    engine_block = 5'd2;
    engine_busy = 1'b1;
    engine_erase_err = 1'b1;
    @(negedge clk);
    engine_erase_err = 1'b0;
    host_u.put('0, 16'h0080);
    host_u.idle();
    engine_busy = 1'b0;
    check({16'h0, cmd_data}, 32'h0080);
    expect_rd(1'b1, 21'h020000, 16'h00b0);
    engine_block = '0;
  endtask

  // Every ready/busy mode against one write-engine run
  task automatic t_ready_busy();
    logic [7:0] codes [4];
    int lows_exp [4];
    int lows;
    codes = '{RB_CODE_ERASE, RB_CODE_WRITE, RB_CODE_OFF, RB_CODE_LEVEL};
    lows_exp = '{0, 1, 0, 4};
    engine_op_erase = 1'b0;
    for (int k = 0; k < 4; k++) begin
      host_u.put('0, 16'h0096);
      host_u.put('0, {8'h00, codes[k]});
      host_u.idle();
      repeat (2) @(negedge clk);
      lows = 0;
      for (int i = 0; i < 10; i++) begin
        @(negedge clk);
        if (ready_busy_output === 1'b0) lows++;
        engine_busy = (i < 4);
      end
      check(lows, lows_exp[k]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the two hundred or so cycles of the run
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  // Reset, then the scenarios in turn
  initial begin
    word_mode = 1'b0;
    array_rdata = 16'h5a5a;
    engine_busy = 1'b0;
    engine_op_erase = 1'b0;
    engine_block = '0;
    engine_write_err = 1'b0;
    engine_erase_err = 1'b0;
    engine_vpp_low = 1'b0;
    erase_suspended_flag = 1'b0;
    queue_full_flag = 1'b0;
    lock_nv = '0;
    exp_pb = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_locks();
    t_swap();
    t_pb_write();
    t_seq_load();
    t_seq_err();
    t_sleep_abort();
    t_ready_busy();
    tally_and_finish();
  end
endmodule // tb
